// [verif/core_model.sv]
// model of the core pipeline: fetch, load/store and retirement buses
// driven through its tasks only, each change right after a rising edge
`timescale 1ns/1ps
module core_model
(
  // clock
  input wire logic i_mclk,
  // buses towards the block
  output logic o_fetch_valid,
  output logic [31:0] o_fetch_addr,
  output logic [1:0] o_fetch_tag,
  output logic o_ls_valid,
  output logic [31:0] o_ls_addr,
  output logic [31:0] o_ls_data,
  output logic [1:0] o_ls_tag,
  output logic [1:0] o_retire_valid,
  output logic [1:0] o_retire_tag0,
  output logic [1:0] o_retire_tag1
);
  initial
  begin
    {o_fetch_valid, o_ls_valid, o_retire_valid} = '0;
    {o_fetch_addr, o_fetch_tag, o_ls_addr, o_ls_data, o_ls_tag, o_retire_tag0, o_retire_tag1} = '0;
  end
  // released fetch and load/store buses show the inverse address and data so a stale value never matches by luck; retirement only drops valid
  task automatic fetch(input logic [31:0] fa, input logic [1:0] tg);
    @(posedge i_mclk);
    {o_fetch_valid, o_fetch_addr, o_fetch_tag} <= {1'b1, fa, tg};
    @(posedge i_mclk);
    {o_fetch_valid, o_fetch_addr} <= {1'b0, ~fa};
  endtask
  task automatic ls(input logic [31:0] la, input logic [31:0] ld, input logic [1:0] tg);
    @(posedge i_mclk);
    {o_ls_valid, o_ls_addr, o_ls_data, o_ls_tag} <= {1'b1, la, ld, tg};
    @(posedge i_mclk);
    {o_ls_valid, o_ls_addr, o_ls_data} <= {1'b0, ~la, ~ld};
  endtask
  task automatic retire(input logic [1:0] sl, input logic [1:0] t0, input logic [1:0] t1);
    @(posedge i_mclk);
    {o_retire_valid, o_retire_tag0, o_retire_tag1} <= {sl, t0, t1};
    @(posedge i_mclk);
    o_retire_valid <= 2'b00;
  endtask
endmodule // core_model

// [verif/watchpoint_breakpoint_logic_tb.sv]
// self-checking bench: register access over APB, core traffic from core_model
// expected pin results are queued by the driver and checked by a monitor
`timescale 1ns/1ps
module watchpoint_breakpoint_logic_tb;
  logic i_mclk, i_srst, psel, penable, pwrite, ri, dm, dn, pb, pready, pslverr, ibrk, lbrk, ebrk, exc, fv, lv, m;
  logic ev_seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, a, la, ld, fa, fad, lad, ldd;
  logic [3:0] iw;
  logic [1:0] lw, ft, lt, rv, rt0, rt1, lsz;
  logic [32:0] rd_q[$];
  logic [9:0] ev_q[$];
  int fails = 0;
  int n_compared = 0;

  watchpoint_breakpoint_logic watchpoint_breakpoint_logic_inst (.i_mclk(i_mclk), .i_srst(i_srst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_fetch_valid(fv), .i_fetch_addr(fad), .i_fetch_tag(ft),
    .i_ls_valid(lv), .i_ls_addr(lad), .i_ls_size(lsz), .i_ls_data(ldd), .i_ls_tag(lt),
    .i_retire_valid(rv), .i_retire_tag0(rt0), .i_retire_tag1(rt1), .i_recoverable_interrupt_bit(ri),
    .i_devport_brk_maskable(dm), .i_devport_brk_nonmask(dn), .i_periph_brk(pb), .o_instr_watchpoint(iw),
    .o_ls_watchpoint(lw), .o_instr_breakpoint(ibrk), .o_ls_breakpoint(lbrk), .o_ext_breakpoint(ebrk),
    .o_exception_req(exc));
  core_model core_model_inst (.i_mclk(i_mclk), .o_fetch_valid(fv), .o_fetch_addr(fad), .o_fetch_tag(ft),
    .o_ls_valid(lv), .o_ls_addr(lad), .o_ls_data(ldd), .o_ls_tag(lt), .o_retire_valid(rv),
    .o_retire_tag0(rt0), .o_retire_tag1(rt1));

  initial
  begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  task automatic finish_test;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic [7:0] ad, input logic wr, input logic [31:0] wd);
    @(posedge i_mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, ad, wd};
    @(posedge i_mclk);
    penable <= 1'b1;
    do @(posedge i_mclk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask

  task automatic rd(input logic [7:0] ad, input logic [32:0] e);
    rd_q.push_back(e);
    apb(ad, 1'b0, 32'h0);
  endtask

  task automatic instr(input logic [31:0] f, input logic [9:0] e);
    core_model_inst.fetch(f, 2'h1);
    ev_q.push_back(e);
    core_model_inst.retire(2'b01, 2'h1, 2'h1);
  endtask

  task automatic ldst(input logic [31:0] f, input logic [9:0] e);
    core_model_inst.fetch(f, 2'h3);
    core_model_inst.ls(la, ld, 2'h3);
    ev_q.push_back(e);
    core_model_inst.retire(2'b01, 2'h3, 2'h3);
  endtask

  always @(posedge i_mclk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      check({pslverr, prdata}, rd_q.pop_front());
    ev_seen <= !i_srst && ((|rv) || dm || dn || pb);
  end
  // pins stand one cycle after the cause, so look mid-cycle
  always @(negedge i_mclk)
    if (ev_seen === 1'b1)
      check({23'h0, iw, lw, ibrk, lbrk, ebrk, exc}, {23'h0, ev_q.pop_front()});

  initial
  begin
    {psel, penable, pwrite, ri, dm, dn, pb, ev_seen} = '0;
    {paddr, pwdata} = '0;
    lsz = wpbp_pkg::SZ_WORD;
    i_srst = 1'b1;
    a = ($urandom(91171) & 32'h0fff_fff0) | 32'h0000_0100;
    la = $urandom & 32'h0fff_fffc;
    ld = $urandom;
    repeat (3) @(posedge i_mclk);
    i_srst <= 1'b0;
    ri <= 1'b1;
    rd(wpbp_pkg::OFS_STATUS, 33'h0);
    rd(8'h38, {1'b1, 32'h0});
    apb(wpbp_pkg::OFS_STATUS, 1'b1, 32'hffff_ffff);
    rd(wpbp_pkg::OFS_STATUS, 33'h0);
    apb(wpbp_pkg::OFS_CMP_FIRST, 1'b1, a);
    for (int c = 0; c < 4; c++)
    begin
      apb(wpbp_pkg::OFS_INSTR_CTRL, 1'b1, 32'h400 | 32'(c));
      for (int k = 0; k < 3; k++)
      begin
        fa = a + 32'(k * 4) - 32'h4;
        m = (c == 0) ? (fa == a) : (c == 1) ? (fa != a) : (c == 2) ? (fa > a) : (fa < a);
        instr(fa, {3'b000, m, 2'b00, m, 2'b00, m});
      end
    end
    // A above, B below: AND gives in range, OR gives either side
    apb(8'h04, 1'b1, a + 32'h8);
    apb(wpbp_pkg::OFS_INSTR_CTRL, 1'b1, 32'h10e);
    instr(a + 32'h4, {4'b0011, 6'h0});
    instr(a + 32'hc, {4'b0010, 6'h0});
    apb(wpbp_pkg::OFS_INSTR_CTRL, 1'b1, 32'h400);
    ri <= 1'b0;
    instr(a, {4'b0001, 6'h0});
    apb(wpbp_pkg::OFS_LS_CTRL_TWO, 1'b1, 32'h8000_0000);
    instr(a, {4'b0001, 6'b001001});
    ri <= 1'b1;
    // two instructions retiring together take the count from 2 to 0
    apb(wpbp_pkg::OFS_INSTR_CTRL, 1'b1, 32'h0);
    apb(wpbp_pkg::OFS_CNT_INSTR, 1'b1, 32'h0002_0002);
    core_model_inst.fetch(a, 2'h1);
    core_model_inst.fetch(a, 2'h2);
    ev_q.push_back({4'b0001, 6'b001001});
    core_model_inst.retire(2'b11, 2'h1, 2'h2);
    rd(wpbp_pkg::OFS_STATUS, {1'b0, 32'h1});
    instr(a, {4'b0001, 6'h0});
    // repeated transfers of one instruction count once
    apb(wpbp_pkg::OFS_LS_CTRL_TWO, 1'b1, 32'h1);
    apb(8'h10, 1'b1, la);
    apb(wpbp_pkg::OFS_CNT_LS, 1'b1, 32'h0002_0002);
    core_model_inst.fetch(a + 32'h40, 2'h3);
    core_model_inst.ls(la + 32'h2, ld, 2'h3);
    core_model_inst.ls(la, ld, 2'h3);
    ev_q.push_back({4'b0000, 6'b010000});
    core_model_inst.retire(2'b01, 2'h3, 2'h3);
    ldst(a + 32'h40, {4'b0000, 6'b010101});
    apb(wpbp_pkg::OFS_LS_CTRL_TWO, 1'b1, 32'h4011);
    ldst(a + 32'h40, 10'h0);
    ldst(a, {4'b0001, 6'b010101});
    // data lane G signed greater than 0x10 on lw1: negative misses, narrow access refused
    apb(8'h18, 1'b1, 32'h10);
    apb(wpbp_pkg::OFS_LS_CTRL, 1'b1, 32'h20);
    apb(wpbp_pkg::OFS_LS_CTRL_TWO, 1'b1, 32'h5_0200);
    ld = 32'hffff_fff0;
    ldst(a + 32'h40, 10'h0);
    ld = 32'h20;
    ldst(a + 32'h40, {4'b0000, 6'b100000});
    lsz <= wpbp_pkg::SZ_HALF;
    ldst(a + 32'h40, 10'h0);
    for (int k = 0; k < 6; k++)
    begin
      @(posedge i_mclk);
      ri <= k[0];
      {dm, dn, pb} <= 3'b001 << (k >> 1);
      m = ((k >> 1) == 1) || k[0];
      ev_q.push_back({6'h0, 2'b00, m, m});
      @(posedge i_mclk);
      {dm, dn, pb} <= 3'b000;
    end
    repeat (4) @(posedge i_mclk);
    finish_test;
  end

  initial
  begin
    repeat (20000) @(posedge i_mclk);
    fails++;
    finish_test;
  end
endmodule // watchpoint_breakpoint_logic_tb

// [verif/wpbp_props.sv]
// port-level assertions for the watchpoint and breakpoint block
// bound to every instance of the block; one clock, synchronous reset
`timescale 1ns/1ps
module wpbp_props
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // inputs watched
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [1:0] i_retire_valid,
  input wire logic i_recoverable_interrupt_bit,
  input wire logic i_devport_brk_nonmask,
  input wire logic i_periph_brk,
  // outputs watched
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [3:0] o_instr_watchpoint,
  input wire logic [1:0] o_ls_watchpoint,
  input wire logic o_instr_breakpoint,
  input wire logic o_ls_breakpoint,
  input wire logic o_ext_breakpoint,
  input wire logic o_exception_req
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  property p_pins_at_retire;
    (|o_instr_watchpoint || |o_ls_watchpoint) |-> $past(|i_retire_valid);
  endproperty
  a_pins_at_retire: assert property (p_pins_at_retire) else $error("pin pulse without retirement");
  property p_nonmask_taken;
    i_devport_brk_nonmask |=> o_ext_breakpoint;
  endproperty
  a_nonmask_taken: assert property (p_nonmask_taken) else $error("non-maskable request lost");
  property p_periph_taken;
    i_periph_brk && i_recoverable_interrupt_bit |=> o_ext_breakpoint;
  endproperty
  a_periph_taken: assert property (p_periph_taken) else $error("peripheral request lost");
  property p_ibrk_pin;
    o_instr_breakpoint |-> |o_instr_watchpoint;
  endproperty
  a_ibrk_pin: assert property (p_ibrk_pin) else $error("instruction break without watchpoint");
  property p_lbrk_pin;
    o_ls_breakpoint |-> |o_ls_watchpoint;
  endproperty
  a_lbrk_pin: assert property (p_lbrk_pin) else $error("load/store break without watchpoint");
  property p_exc_any;
    o_exception_req == (o_instr_breakpoint || o_ls_breakpoint || o_ext_breakpoint);
  endproperty
  a_exc_any: assert property (p_exc_any) else $error("exception request mismatch");
  property p_apb_answer;
    i_psel && !i_penable |=> o_pready ##1 !o_pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("register access answer late");
  property p_err_ready;
    o_pslverr |-> o_pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  c_ibrk: cover property (o_instr_breakpoint);
  c_lbrk: cover property (o_ls_breakpoint);
  c_ebrk: cover property (o_ext_breakpoint);
  c_err: cover property (o_pslverr);
endmodule // wpbp_props

bind watchpoint_breakpoint_logic wpbp_props wpbp_props_inst (.i_mclk(i_mclk), .i_srst(i_srst), .i_psel(i_psel),
  .i_penable(i_penable), .i_retire_valid(i_retire_valid), .i_recoverable_interrupt_bit(i_recoverable_interrupt_bit),
  .i_devport_brk_nonmask(i_devport_brk_nonmask), .i_periph_brk(i_periph_brk), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_instr_watchpoint(o_instr_watchpoint), .o_ls_watchpoint(o_ls_watchpoint),
  .o_instr_breakpoint(o_instr_breakpoint), .o_ls_breakpoint(o_ls_breakpoint),
  .o_ext_breakpoint(o_ext_breakpoint), .o_exception_req(o_exception_req));

// [verilog/watchpoint_breakpoint_logic.sv]
// watchpoint and breakpoint logic: comparators, AND-OR structures, counters, APB registers
// assumes the core tags each in-flight instruction with a 2-bit id and frees it at retirement
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module watchpoint_breakpoint_logic
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // instruction fetch bus
  input wire logic i_fetch_valid,
  input wire logic [31:0] i_fetch_addr,
  input wire logic [1:0] i_fetch_tag,
  // load/store bus
  input wire logic i_ls_valid,
  input wire logic [31:0] i_ls_addr,
  input wire logic [1:0] i_ls_size,
  input wire logic [31:0] i_ls_data,
  input wire logic [1:0] i_ls_tag,
  // retirement, two slots
  input wire logic [1:0] i_retire_valid,
  input wire logic [1:0] i_retire_tag0,
  input wire logic [1:0] i_retire_tag1,
  // masking and external requests
  input wire logic i_recoverable_interrupt_bit,
  input wire logic i_devport_brk_maskable,
  input wire logic i_devport_brk_nonmask,
  input wire logic i_periph_brk,
  // watchpoint pins and breakpoints
  output logic [3:0] o_instr_watchpoint,
  output logic [1:0] o_ls_watchpoint,
  output logic o_instr_breakpoint,
  output logic o_ls_breakpoint,
  output logic o_ext_breakpoint,
  output logic o_exception_req
);

  typedef struct packed {
    logic [7:0][31:0] cmp_val;
    logic [31:0] ictrl;
    logic [31:0] lctrl;
    logic [31:0] load_store_control_two;
    logic [1:0][15:0] cnt;
    logic [1:0][1:0] cnt_cfg;
    wpbp_pkg::cnt_state_t cnt_st0;
    wpbp_pkg::cnt_state_t cnt_st1;
    logic [3:0][3:0] tag_iw;
    logic [3:0][1:0] tag_lw;
    logic [3:0] iw_pins;
    logic [1:0] lw_pins;
    logic ibrk;
    logic lbrk;
    logic ebrk;
    logic exc;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  function automatic logic cond_hit(input logic [1:0] cond, input logic eq, input logic lt);
    case (cond)
      wpbp_pkg::COND_EQ: cond_hit = eq;
      wpbp_pkg::COND_NE: cond_hit = !eq;
      wpbp_pkg::COND_GT: cond_hit = !eq && !lt;
      default: cond_hit = lt;
    endcase
  endfunction

  function automatic logic pair_op(input logic [1:0] op, input logic x, input logic y);
    case (op)
      wpbp_pkg::OP_IGNORE: pair_op = 1'b1;
      wpbp_pkg::OP_FIRST: pair_op = x;
      wpbp_pkg::OP_AND: pair_op = x && y;
      default: pair_op = x || y;
    endcase
  endfunction

  // data lane compare; floats and stored integer words arrive as raw 32-bit patterns, and
  // signed compare orders positive singles correctly while negatives need software care
  function automatic logic [1:0] data_cmp(input logic [31:0] d, input logic [31:0] v,
                                          input logic [1:0] sz, input logic [1:0] ofs,
                                          input logic sgn);
    logic [32:0] a;
    logic [32:0] b;
    a = 33'h0_0000_0000;
    b = 33'h0_0000_0000;
    case (sz)
      wpbp_pkg::SZ_BYTE:
      begin
        a = {{25{sgn & d[8*ofs+7]}}, d[8*ofs +: 8]};
        b = {{25{sgn & v[8*ofs+7]}}, v[8*ofs +: 8]};
      end
      wpbp_pkg::SZ_HALF:
      begin
        a = {{17{sgn & d[16*ofs[1]+15]}}, d[16*ofs[1] +: 16]};
        b = {{17{sgn & v[16*ofs[1]+15]}}, v[16*ofs[1] +: 16]};
      end
      default:
      begin
        a = {sgn & d[31], d};
        b = {sgn & v[31], v};
      end
    endcase
    data_cmp = {a == b, $signed(a) < $signed(b)};
  endfunction

  logic [3:0] im;
  logic [3:0] iw;
  logic [1:0] lam;
  logic [1:0] ldm;
  logic [1:0] lw;
  logic [31:0] amask;
  logic [1:0] dres;
  logic [6:0] cfg;
  logic size_ok;
  logic [3:0] r_iw;
  logic [1:0] r_lw;
  logic [1:0] dec0;
  logic [1:0] dec1;
  logic exp0;
  logic exp1;
  logic ibrk_evt;
  logic lbrk_evt;
  logic int_ok;
  logic wr_en;
  logic [5:0] widx;
  logic [5:0] ridx;

  always_comb
  begin
    st_nxt = st_r;
    im = 4'h0;
    lam = 2'h0;
    ldm = 2'h0;
    lw = 2'h0;
    dres = 2'h0;
    cfg = 7'h00;
    // RULE1: eight comparators feed two AND-OR structures and two counters
    // RULE22: 30-bit word address compares, equal and less-than per comparator
    for (int k = 0; k < 4; k++)
    begin
      // RULE3: condition decode
      im[k] = cond_hit(st_r.ictrl[2*k +: 2], i_fetch_addr[31:2] == st_r.cmp_val[k][31:2],
                       i_fetch_addr[31:2] < st_r.cmp_val[k][31:2]);
    end
    // RULE24: single match or pair joined by AND (in range) / OR (out of range)
    iw[0] = st_r.ictrl[wpbp_pkg::ICTL_PAIR_AB] ? (im[0] & im[1]) : im[0];
    iw[1] = st_r.ictrl[wpbp_pkg::ICTL_PAIR_AB] ? (im[0] | im[1]) : im[1];
    iw[2] = st_r.ictrl[wpbp_pkg::ICTL_PAIR_CD] ? (im[2] & im[3]) : im[2];
    iw[3] = st_r.ictrl[wpbp_pkg::ICTL_PAIR_CD] ? (im[2] | im[3]) : im[3];
    // RULE23: low address bits ignored according to access size
    case (i_ls_size)
      wpbp_pkg::SZ_WORD: amask = 32'hffff_fffc;
      wpbp_pkg::SZ_HALF: amask = 32'hffff_fffe;
      default: amask = 32'hffff_ffff;
    endcase
    // RULE2: two address and two data comparators on the load/store bus
    for (int k = 0; k < 2; k++)
    begin
      lam[k] = cond_hit(st_r.lctrl[2*k +: 2],
                        (i_ls_addr & amask) == (st_r.cmp_val[4+k] & amask),
                        (i_ls_addr & amask) < (st_r.cmp_val[4+k] & amask));
      // RULE5: RULE6: sized, optionally signed data compare
      dres = data_cmp(i_ls_data, st_r.cmp_val[6+k], st_r.load_store_control_two[wpbp_pkg::LCT_SIZE +: 2],
                      i_ls_addr[1:0], st_r.load_store_control_two[wpbp_pkg::LCT_SIGNED]);
      ldm[k] = cond_hit(st_r.lctrl[4+2*k +: 2], dres[1], dres[0]);
    end
    // an access narrower than the compare size never matches
    size_ok = i_ls_size >= st_r.load_store_control_two[wpbp_pkg::LCT_SIZE +: 2];
    // RULE4: RULE8: load/store AND-OR structure
    for (int j = 0; j < 2; j++)
    begin
      cfg = st_r.load_store_control_two[j*wpbp_pkg::LW_CFG_W +: wpbp_pkg::LW_CFG_W];
      lw[j] = i_ls_valid && size_ok && (cfg[3:0] != 4'h0)
              && pair_op(cfg[wpbp_pkg::LW_AOP +: 2], lam[0], lam[1])
              && pair_op(cfg[wpbp_pkg::LW_DOP +: 2], ldm[0], ldm[1])
              // RULE9: qualifying instruction watchpoint of the same instruction
              && (!cfg[wpbp_pkg::LW_QUAL] || st_r.tag_iw[i_ls_tag][cfg[wpbp_pkg::LW_QSEL +: 2]]);
    end
    // RULE10: watchpoints ride with the instruction tag until retirement
    if (i_fetch_valid)
    begin
      st_nxt.tag_iw[i_fetch_tag] = iw;
      st_nxt.tag_lw[i_fetch_tag] = 2'h0;
    end
    // RULE11: repeated transfers or bytes of one instruction merge into one flag
    if (i_ls_valid)
    begin
      st_nxt.tag_lw[i_ls_tag] = st_nxt.tag_lw[i_ls_tag] | lw;
    end
    // RULE12: RULE13: pins merge both retiring slots, counters take each slot
    r_iw = (i_retire_valid[0] ? st_r.tag_iw[i_retire_tag0] : 4'h0)
           | (i_retire_valid[1] ? st_r.tag_iw[i_retire_tag1] : 4'h0);
    r_lw = (i_retire_valid[0] ? st_r.tag_lw[i_retire_tag0] : 2'h0)
           | (i_retire_valid[1] ? st_r.tag_lw[i_retire_tag1] : 2'h0);
    // RULE7: the instruction counter follows one of the first two instruction watchpoints
    dec0 = {1'b0, i_retire_valid[0] & st_r.tag_iw[i_retire_tag0][st_r.cnt_cfg[0][0]]}
           + {1'b0, i_retire_valid[1] & st_r.tag_iw[i_retire_tag1][st_r.cnt_cfg[0][0]]};
    dec1 = {1'b0, i_retire_valid[0] & st_r.tag_lw[i_retire_tag0][st_r.cnt_cfg[1][0]]}
           + {1'b0, i_retire_valid[1] & st_r.tag_lw[i_retire_tag1][st_r.cnt_cfg[1][0]]};
    // RULE17: decrement, expire on reaching zero
    exp0 = (st_r.cnt_st0 == wpbp_pkg::CNT_RUN) && (dec0 != 2'h0) && (st_r.cnt[0] <= {14'h0000, dec0});
    exp1 = (st_r.cnt_st1 == wpbp_pkg::CNT_RUN) && (dec1 != 2'h0) && (st_r.cnt[1] <= {14'h0000, dec1});
    case (st_r.cnt_st0)
      wpbp_pkg::CNT_IDLE: st_nxt.cnt_st0 = wpbp_pkg::CNT_IDLE;
      wpbp_pkg::CNT_RUN:
      begin
        st_nxt.cnt[0] = exp0 ? wpbp_pkg::RST_COUNT : st_r.cnt[0] - {14'h0000, dec0};
        st_nxt.cnt_st0 = exp0 ? wpbp_pkg::CNT_DONE : wpbp_pkg::CNT_RUN;
      end
      // RULE25: expired counter holds
      wpbp_pkg::CNT_DONE: st_nxt.cnt_st0 = wpbp_pkg::CNT_DONE;
      default: st_nxt.cnt_st0 = wpbp_pkg::CNT_IDLE;
    endcase
    case (st_r.cnt_st1)
      wpbp_pkg::CNT_IDLE: st_nxt.cnt_st1 = wpbp_pkg::CNT_IDLE;
      wpbp_pkg::CNT_RUN:
      begin
        st_nxt.cnt[1] = exp1 ? wpbp_pkg::RST_COUNT : st_r.cnt[1] - {14'h0000, dec1};
        st_nxt.cnt_st1 = exp1 ? wpbp_pkg::CNT_DONE : wpbp_pkg::CNT_RUN;
      end
      // RULE25: expired counter holds
      wpbp_pkg::CNT_DONE: st_nxt.cnt_st1 = wpbp_pkg::CNT_DONE;
      default: st_nxt.cnt_st1 = wpbp_pkg::CNT_IDLE;
    endcase
    // RULE15: dedicated watchpoint pins
    st_nxt.iw_pins = r_iw;
    st_nxt.lw_pins = r_lw;
    // RULE16: breakpoint generation per watchpoint enable bits
    ibrk_evt = |(r_iw & st_r.ictrl[wpbp_pkg::ICTL_BRK_EN +: 4]) || exp0;
    lbrk_evt = |(r_lw & st_r.load_store_control_two[wpbp_pkg::LCT_BRK_EN +: 2]) || exp1;
    // RULE19: internal breakpoints masked by the recoverable bit unless no-mask
    int_ok = i_recoverable_interrupt_bit || st_r.load_store_control_two[wpbp_pkg::LCT_NO_MASK];
    st_nxt.ibrk = ibrk_evt && int_ok;
    st_nxt.lbrk = lbrk_evt && int_ok;
    // RULE18: RULE20: external requests, only the non-maskable one bypasses the mask
    st_nxt.ebrk = i_devport_brk_nonmask
                  || ((i_devport_brk_maskable || i_periph_brk) && i_recoverable_interrupt_bit);
    // RULE14: RULE21: only this request reaches the core, watchpoints alone never stall it
    st_nxt.exc = st_nxt.ibrk || st_nxt.lbrk || st_nxt.ebrk;
    // apb: data prepared in setup, one access cycle with pready high
    st_nxt.pready = i_psel && !i_penable;
    st_nxt.pslverr = i_psel && !i_penable && (i_paddr > wpbp_pkg::OFS_LAST);
    ridx = i_paddr[7:2];
    case (i_paddr)
      wpbp_pkg::OFS_INSTR_CTRL: st_nxt.prdata = st_r.ictrl;
      wpbp_pkg::OFS_LS_CTRL: st_nxt.prdata = st_r.lctrl;
      wpbp_pkg::OFS_LS_CTRL_TWO: st_nxt.prdata = st_r.load_store_control_two;
      wpbp_pkg::OFS_CNT_INSTR: st_nxt.prdata = {14'h0000, st_r.cnt_cfg[0], st_r.cnt[0]};
      wpbp_pkg::OFS_CNT_LS: st_nxt.prdata = {14'h0000, st_r.cnt_cfg[1], st_r.cnt[1]};
      wpbp_pkg::OFS_STATUS:
        st_nxt.prdata = {22'h00_0000, st_r.lbrk, st_r.ibrk, st_r.lw_pins, st_r.iw_pins,
                         st_r.cnt_st1 == wpbp_pkg::CNT_DONE, st_r.cnt_st0 == wpbp_pkg::CNT_DONE};
      default: st_nxt.prdata = (i_paddr < wpbp_pkg::OFS_INSTR_CTRL) ? st_r.cmp_val[ridx[2:0]]
                                                                      : wpbp_pkg::RST_WORD;
    endcase
    // RULE16: writes from monitor software or development port land here; reprogram beats count
    wr_en = i_psel && i_penable && st_r.pready && i_pwrite && !st_r.pslverr;
    widx = i_paddr[7:2];
    if (wr_en)
    begin
      case (i_paddr)
        wpbp_pkg::OFS_INSTR_CTRL: st_nxt.ictrl = i_pwdata;
        wpbp_pkg::OFS_LS_CTRL: st_nxt.lctrl = i_pwdata;
        wpbp_pkg::OFS_LS_CTRL_TWO: st_nxt.load_store_control_two = i_pwdata;
        wpbp_pkg::OFS_CNT_INSTR:
        begin
          st_nxt.cnt[0] = i_pwdata[wpbp_pkg::CNT_W-1:0];
          st_nxt.cnt_cfg[0] = i_pwdata[wpbp_pkg::CNT_EN:wpbp_pkg::CNT_SEL];
          st_nxt.cnt_st0 = (i_pwdata[wpbp_pkg::CNT_EN] && i_pwdata[wpbp_pkg::CNT_W-1:0] != 16'h0000)
                           ? wpbp_pkg::CNT_RUN : wpbp_pkg::CNT_IDLE;
        end
        wpbp_pkg::OFS_CNT_LS:
        begin
          st_nxt.cnt[1] = i_pwdata[wpbp_pkg::CNT_W-1:0];
          st_nxt.cnt_cfg[1] = i_pwdata[wpbp_pkg::CNT_EN:wpbp_pkg::CNT_SEL];
          st_nxt.cnt_st1 = (i_pwdata[wpbp_pkg::CNT_EN] && i_pwdata[wpbp_pkg::CNT_W-1:0] != 16'h0000)
                           ? wpbp_pkg::CNT_RUN : wpbp_pkg::CNT_IDLE;
        end
        wpbp_pkg::OFS_STATUS: st_nxt.ictrl = st_nxt.ictrl;
        default: st_nxt.cmp_val[widx[2:0]] = i_pwdata;
      endcase
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      st_r <= '0;
      st_r.cnt_st0 <= wpbp_pkg::CNT_IDLE;
      st_r.cnt_st1 <= wpbp_pkg::CNT_IDLE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign o_prdata = st_r.prdata;
  assign o_pready = st_r.pready;
  assign o_pslverr = st_r.pslverr;
  assign o_instr_watchpoint = st_r.iw_pins;
  assign o_ls_watchpoint = st_r.lw_pins;
  assign o_instr_breakpoint = st_r.ibrk;
  assign o_ls_breakpoint = st_r.lbrk;
  assign o_ext_breakpoint = st_r.ebrk;
  assign o_exception_req = st_r.exc;

endmodule // watchpoint_breakpoint_logic

// [verilog/wpbp_pkg.sv]
// constants, register map and encodings for the watchpoint and breakpoint logic
// assumes a single 100 MHz core clock and an APB master with 32-bit data
// Function
// RULE1: eight comparators, two counters, two AND-OR structures for instruction and load/store.
// RULE2: four instruction-address, two load/store-address, two load/store-data comparators.
// RULE3: each comparator matches on equal, not equal, greater than or less than.
// RULE4: AND-OR joins two comparator results for in-range and out-of-range detection.
// RULE5: data comparators take integer, single float and store-float-as-integer words.
// RULE6: integer compares at byte, half-word or word size, signed or unsigned.
// RULE7: instruction matches form instruction watchpoints, breakpoint, counted expiry breaks.
// RULE8: load/store logic combines watchpoints and matches; breaks directly or via counter.
// RULE9: qualified load/store watchpoint needs its instruction to hit the qualifying watchpoint.
// RULE10: watchpoints travel with their instruction and reach pins at retirement.
// RULE11: repeated matches within one instruction are reported and counted once.
// RULE12: several instructions retiring together report their watchpoints in one cycle.
// RULE13: pins may show a shared event once; counters still count each instruction.
// RULE14: watchpoints never alter flow or timing; only enabled breakpoints do.
// RULE15: every watchpoint is shown on dedicated output pins.
// RULE16: breakpoint enables are written by software monitor or development port.
// RULE17: a counter decrements per occurrence and breaks when it reaches zero.
// RULE18: development port or on-chip peripheral requests raise an external breakpoint.
// RULE19: internal breakpoints masked while recoverable bit clear unless no-mask set.
// RULE20: maskable port and peripheral breaks obey the mask; non-maskable port break never.
// RULE21: an unmasked enabled breakpoint makes the processor take an exception.
// RULE22: instruction comparators are 30 bits, giving equal and less-than outputs.
// RULE23: load/store address compare ignores two low bits on word, one on half-word.
// RULE24: instruction watchpoint is single match, AND of pair or OR of pair.
// RULE25: an expired counter holds until it is reprogrammed.
package wpbp_pkg;

  // register word offsets (byte addresses)
  localparam logic [7:0] OFS_CMP_FIRST = 8'h00;
  localparam logic [7:0] OFS_INSTR_CTRL = 8'h20;
  localparam logic [7:0] OFS_LS_CTRL = 8'h24;
  localparam logic [7:0] OFS_LS_CTRL_TWO = 8'h28;
  localparam logic [7:0] OFS_CNT_INSTR = 8'h2c;
  localparam logic [7:0] OFS_CNT_LS = 8'h30;
  localparam logic [7:0] OFS_STATUS = 8'h34;
  localparam logic [7:0] OFS_LAST = 8'h34;

  // instruction control fields
  localparam int ICTL_PAIR_AB = 8;
  localparam int ICTL_PAIR_CD = 9;
  localparam int ICTL_BRK_EN = 10;

  // load/store control two fields; each watchpoint config is 7 bits
  localparam int LW_CFG_W = 7;
  localparam int LW_AOP = 0;
  localparam int LW_DOP = 2;
  localparam int LW_QUAL = 4;
  localparam int LW_QSEL = 5;
  localparam int LCT_BRK_EN = 14;
  localparam int LCT_SIGNED = 16;
  localparam int LCT_SIZE = 17;
  localparam int LCT_NO_MASK = 31;

  // counter register fields
  localparam int CNT_W = 16;
  localparam int CNT_SEL = 16;
  localparam int CNT_EN = 17;

  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] RST_COUNT = 16'h0000;

  // match conditions
  localparam logic [1:0] COND_EQ = 2'h0;
  localparam logic [1:0] COND_NE = 2'h1;
  localparam logic [1:0] COND_GT = 2'h2;
  localparam logic [1:0] COND_LT = 2'h3;

  // access and compare sizes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;

  // pair operators for the load/store AND-OR structure
  localparam logic [1:0] OP_IGNORE = 2'h0;
  localparam logic [1:0] OP_FIRST = 2'h1;
  localparam logic [1:0] OP_AND = 2'h2;
  localparam logic [1:0] OP_OR = 2'h3;

  typedef enum logic [2:0] {
    CNT_IDLE = 3'b001,
    CNT_RUN = 3'b010,
    CNT_DONE = 3'b100
  } cnt_state_t;

endpackage
